// file: rtl/tsi_cfg.svh
`ifndef TSI_CFG_SVH
`define TSI_CFG_SVH

// ==========================================================================
// Register map, word index on the bus; the byte address is four times it.
// ==========================================================================
`define TSI_IDX_CTRL 6'h00
`define TSI_IDX_STATUS 6'h01
`define TSI_WIN_BIT 5

// ==========================================================================
// Control register fields and reset value.
// ==========================================================================
`define TSI_CR_SM 7
`define TSI_CR_ME 6
`define TSI_CR_MS_HI 4
`define TSI_CR_MS_LO 3
`define TSI_CR_STA_HI 2
`define TSI_CR_STA_LO 0
`define TSI_CR_RESET 8'h00

// ==========================================================================
// Channel control memory entry fields and reset value.
// ==========================================================================
`define TSI_CC_OE 0
`define TSI_CC_CBIT 1
`define TSI_CC_MSG 2
`define TSI_CC_CONST 3
`define TSI_CC_RESET 4'h0
`define TSI_SM_RESET 8'h00

// ==========================================================================
// Serial timing counts.
// ==========================================================================
`define TSI_SERIAL_CLK_KHZ 4096
`define TSI_BITS_PER_FRAME 256
`define TSI_POS_MAX 9'h1ff
`define TSI_IDLE_EDGES 4'hf
`define TSI_NUM_BUF 3

`endif

// file: rtl/tsi_pkg.sv
package tsi_pkg;

    typedef enum logic [1:0] {
        TSI_MS_NONE,
        TSI_MS_DATA,
        TSI_MS_SMM,
        TSI_MS_CCM
    } tsi_memsel_t;

    typedef logic [7:0] tsi_byte_t;
    typedef logic [3:0] tsi_ctl_t;
    typedef logic [1:0] tsi_buf_t;

endpackage

// file: rtl/tsi_top.sv
`timescale 1ns/1ps
`include "tsi_cfg.svh"
module tsi_top (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic serial_clock_input,
    input wire logic frame_sync_input,
    input wire logic [7:0] serial_input_streams,
    input wire logic global_output_drive_enable,
    output logic [7:0] serial_output_streams,
    output logic [7:0] serial_output_streams_oe_n,
    output logic control_bit_output
);
    import tsi_pkg::*;

    // ======================================================================
    // Serial clock edges and frame format detection.
    // ======================================================================
    logic sclk_prev_reg;
    logic idle_lvl_reg;
    logic [3:0] idle_cnt_reg;
    logic gci_reg;
    logic locked_reg;
    logic fs_prev_reg;
    logic sclk_rise;
    logic sclk_fall;
    logic bnd_edge;
    logic smp_edge;
    logic fs_active;

    assign sclk_rise = serial_clock_input & ~sclk_prev_reg;
    assign sclk_fall = ~serial_clock_input & sclk_prev_reg;
    // Before a format is known the active-high edge choice is used.
    assign bnd_edge = (locked_reg && !gci_reg) ? sclk_fall : sclk_rise;
    assign smp_edge = (locked_reg && !gci_reg) ? sclk_rise : sclk_fall;
    assign fs_active = (frame_sync_input == gci_reg);

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            sclk_prev_reg <= 1'b0;
        end else begin
            sclk_prev_reg <= serial_clock_input;
        end
    end

    // The pulse is short, so the level held for many clocks is the idle one.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            idle_lvl_reg <= 1'b0;
            idle_cnt_reg <= 4'h0;
        end else if (sclk_rise) begin
            if (frame_sync_input == idle_lvl_reg) begin
                if (idle_cnt_reg != `TSI_IDLE_EDGES) begin
                    idle_cnt_reg <= idle_cnt_reg + 4'h1;
                end
            end else begin
                idle_lvl_reg <= frame_sync_input;
                idle_cnt_reg <= 4'h0;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            gci_reg <= 1'b1;
            locked_reg <= 1'b0;
        end else if (sclk_rise && idle_cnt_reg == `TSI_IDLE_EDGES) begin
            gci_reg <= ~idle_lvl_reg;
            locked_reg <= 1'b1;
        end
    end

    // ======================================================================
    // Frame position: half-bit counter, 512 steps per frame.
    // ======================================================================
    logic [8:0] pos_reg;
    logic [8:0] pos_next;
    logic frame_start;
    logic [1:0] fidx_reg;
    logic [1:0] fcur;
    logic [1:0] rbuf;
    logic [4:0] out_ch;

    function automatic logic [1:0] inc3(input logic [1:0] v);
        inc3 = (v == 2'h2) ? 2'h0 : v + 2'h1;
    endfunction

    function automatic logic [1:0] dec3(input logic [1:0] v);
        dec3 = (v == 2'h0) ? 2'h2 : v - 2'h1;
    endfunction

    // A fresh pulse resets the count; otherwise it wraps by itself.
    assign pos_next = (locked_reg && fs_active && !fs_prev_reg) ? 9'h000 :
        pos_reg + 9'h001;
    assign frame_start = (pos_next == 9'h000);
    assign fcur = frame_start ? inc3(fidx_reg) : fidx_reg;
    assign out_ch = pos_next[8:4] + 5'h01;
    // Channel 0 is fetched in the last slot of the frame before its own.
    assign rbuf = (out_ch == 5'h00) ? dec3(fcur) : inc3(fcur);

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pos_reg <= `TSI_POS_MAX;
            fs_prev_reg <= 1'b0;
            fidx_reg <= 2'h0;
        end else if (bnd_edge) begin
            pos_reg <= pos_next;
            fs_prev_reg <= fs_active;
            if (frame_start) begin
                fidx_reg <= inc3(fidx_reg);
            end
        end
    end

    // ======================================================================
    // Receive: sample at three quarters of each bit, hold the byte a slot.
    // ======================================================================
    logic [7:0] in_sh_reg [0:7];
    logic [7:0] hold_reg [0:7];
    logic [4:0] hold_ch_reg;
    logic [1:0] hold_buf_reg;
    logic hold_valid_reg;
    logic rx_sample;
    logic wr_dmem;

    assign rx_sample = smp_edge && pos_reg[0];
    // Writing in the middle of the next slot keeps slot n+2 in the next frame.
    assign wr_dmem = rx_sample && pos_reg[3:1] == 3'h3 && hold_valid_reg;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            for (int s = 0; s < 8; s++) begin
                in_sh_reg[s] <= 8'h00;
                hold_reg[s] <= 8'h00;
            end
            hold_ch_reg <= 5'h00;
            hold_buf_reg <= 2'h0;
            hold_valid_reg <= 1'b0;
        end else if (rx_sample) begin
            for (int s = 0; s < 8; s++) begin
                in_sh_reg[s] <= {in_sh_reg[s][6:0], serial_input_streams[s]};
                if (pos_reg[3:1] == 3'h7) begin
                    hold_reg[s] <= {in_sh_reg[s][6:0], serial_input_streams[s]};
                end
            end
            if (pos_reg[3:1] == 3'h7) begin
                hold_ch_reg <= pos_reg[8:4];
                hold_buf_reg <= fidx_reg;
                hold_valid_reg <= 1'b1;
            end
        end
    end

    // ======================================================================
    // Data memories: one live copy for variable delay, three frame buffers.
    // ======================================================================
    tsi_byte_t dmem_var [0:255];
    tsi_byte_t dmem_con [0:`TSI_NUM_BUF-1][0:255];

    always_ff @(posedge clk_sys) begin
        if (wr_dmem) begin
            for (int s = 0; s < 8; s++) begin
                dmem_var[{3'(s), hold_ch_reg}] <= hold_reg[s];
                dmem_con[hold_buf_reg][{3'(s), hold_ch_reg}] <= hold_reg[s];
            end
        end
    end

    // ======================================================================
    // Register bus.
    // ======================================================================
    tsi_byte_t smm [0:255];
    tsi_ctl_t ccm [0:255];
    logic [7:0] ctrl_reg;
    logic [5:0] idx;
    logic [7:0] maddr;
    tsi_memsel_t msel;
    logic acc_err;
    logic [31:0] rdata;
    logic wr_ctrl;
    logic wr_smm;
    logic wr_ccm;
    logic wr_go;

    assign idx = paddr[7:2];
    assign maddr = {ctrl_reg[`TSI_CR_STA_HI:`TSI_CR_STA_LO], idx[4:0]};
    assign msel = tsi_memsel_t'(ctrl_reg[`TSI_CR_MS_HI:`TSI_CR_MS_LO]);
    assign wr_go = psel && penable && pready && pwrite && !acc_err;

    always_comb begin
        acc_err = 1'b0;
        rdata = 32'h0000_0000;
        wr_ctrl = 1'b0;
        wr_smm = 1'b0;
        wr_ccm = 1'b0;
        if (idx == `TSI_IDX_CTRL) begin
            rdata = {24'h00_0000, ctrl_reg};
            wr_ctrl = 1'b1;
        end else if (idx == `TSI_IDX_STATUS) begin
            rdata = {30'h0000_0000, gci_reg, locked_reg};
            acc_err = pwrite;
        end else if (idx[`TSI_WIN_BIT]) begin
            if (ctrl_reg[`TSI_CR_SM]) begin
                rdata = {24'h00_0000, dmem_var[maddr]};
                wr_smm = 1'b1;
            end else begin
                unique case (msel)
                    TSI_MS_NONE: acc_err = 1'b1;
                    TSI_MS_DATA: begin
                        rdata = {24'h00_0000, dmem_var[maddr]};
                        acc_err = pwrite;
                    end
                    TSI_MS_SMM: begin
                        rdata = {24'h00_0000, smm[maddr]};
                        wr_smm = 1'b1;
                    end
                    TSI_MS_CCM: begin
                        rdata = {28'h000_0000, ccm[maddr]};
                        wr_ccm = 1'b1;
                    end
                endcase
            end
        end else begin
            acc_err = 1'b1;
        end
    end

    // One wait state: the answer is registered, the write lands on completion.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else if (psel && penable && !pready) begin
            pready <= 1'b1;
            pslverr <= acc_err;
            prdata <= (pwrite || acc_err) ? 32'h0000_0000 : rdata;
        end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ctrl_reg <= `TSI_CR_RESET;
        end else if (wr_go && wr_ctrl) begin
            ctrl_reg <= pwdata[7:0];
        end
    end

    // Message bytes and control entries change only by software.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            for (int a = 0; a < 256; a++) begin
                smm[a] <= `TSI_SM_RESET;
                ccm[a] <= `TSI_CC_RESET;
            end
        end else if (wr_go) begin
            if (wr_smm) begin
                smm[maddr] <= pwdata[7:0];
            end
            if (wr_ccm) begin
                ccm[maddr] <= pwdata[3:0];
            end
        end
    end

    // ======================================================================
    // Fetch: at the start of slot k, gather everything for slot k+1.
    // ======================================================================
    logic [7:0] nxt_byte_reg [0:7];
    logic [7:0] nxt_oe_reg;
    logic [7:0] nxt_cb_reg;
    logic fetch;
    logic me;

    assign fetch = bnd_edge && pos_next[3:0] == 4'h0;
    assign me = ctrl_reg[`TSI_CR_ME];

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            for (int s = 0; s < 8; s++) begin
                nxt_byte_reg[s] <= 8'h00;
            end
            nxt_oe_reg <= 8'h00;
            nxt_cb_reg <= 8'h00;
        end else if (fetch) begin
            for (int s = 0; s < 8; s++) begin
                if (me || ccm[{3'(s), out_ch}][`TSI_CC_MSG]) begin
                    nxt_byte_reg[s] <= smm[{3'(s), out_ch}];
                end else if (ccm[{3'(s), out_ch}][`TSI_CC_CONST]) begin
                    nxt_byte_reg[s] <= dmem_con[rbuf][smm[{3'(s), out_ch}]];
                end else begin
                    nxt_byte_reg[s] <= dmem_var[smm[{3'(s), out_ch}]];
                end
                nxt_oe_reg[s] <= me || ccm[{3'(s), out_ch}][`TSI_CC_OE];
                nxt_cb_reg[s] <= ccm[{3'(s), out_ch}][`TSI_CC_CBIT];
            end
        end
    end

    // ======================================================================
    // Transmit: shift out on each bit boundary.
    // ======================================================================
    logic [7:0] out_sh_reg [0:7];
    logic [7:0] cur_oe_reg;
    logic [7:0] cur_cb_reg;
    logic tx_bit;
    logic tx_load;

    assign tx_bit = bnd_edge && !pos_next[0];
    assign tx_load = tx_bit && pos_next[3:1] == 3'h0;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            for (int s = 0; s < 8; s++) begin
                out_sh_reg[s] <= 8'h00;
            end
            serial_output_streams <= 8'h00;
            cur_oe_reg <= 8'h00;
            cur_cb_reg <= 8'h00;
            control_bit_output <= 1'b0;
        end else if (tx_bit) begin
            for (int s = 0; s < 8; s++) begin
                if (tx_load) begin
                    serial_output_streams[s] <= nxt_byte_reg[s][7];
                    out_sh_reg[s] <= {nxt_byte_reg[s][6:0], 1'b0};
                end else begin
                    serial_output_streams[s] <= out_sh_reg[s][7];
                    out_sh_reg[s] <= {out_sh_reg[s][6:0], 1'b0};
                end
            end
            if (tx_load) begin
                cur_oe_reg <= nxt_oe_reg;
                cur_cb_reg <= nxt_cb_reg;
                control_bit_output <= nxt_cb_reg[0];
            end else begin
                control_bit_output <= cur_cb_reg[pos_next[3:1]];
            end
        end
    end

    // Enables follow the drive pin every system cycle, not only on edges.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            serial_output_streams_oe_n <= 8'hff;
        end else begin
            serial_output_streams_oe_n <= ~({8{global_output_drive_enable}} & cur_oe_reg);
        end
    end

endmodule

// file: sim/tsi_top_asserts.sv
`timescale 1ns/1ps
// ========================================
// Bus and output enable checks at the block's ports.
module tsi_top_asserts (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic global_output_drive_enable,
    input wire logic [7:0] serial_output_streams_oe_n
);
    logic [1:0] ms_reg;
    logic sm_reg;

    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);

    // Shadow of the memory select so window refusals can be predicted.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ms_reg <= 2'h0;
            sm_reg <= 1'b0;
        end else if (psel && penable && pready && !pslverr && pwrite && paddr[7:2] == 6'h00) begin
            ms_reg <= pwdata[4:3];
            sm_reg <= pwdata[7];
        end
    end

    sequence acc_s;
        psel && penable && !pready;
    endsequence
    sequence win_s;
        acc_s ##0 paddr[7];
    endsequence

    apb_wait_a: assert property (acc_s |=> pready)
        else $error("ready missing after access");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("ready held too long");
    ready_cause_a: assert property (pready |-> $past(psel && penable))
        else $error("ready without access");
    err_data_a: assert property (pslverr |-> pready && prdata == 32'h0)
        else $error("error without ready or with data");
    status_ro_a: assert property (acc_s ##0 (pwrite && paddr[7:2] == 6'h01) |=> pslverr)
        else $error("status write accepted");
    unmapped_a: assert property (acc_s ##0 (paddr[7:2] inside {[6'h02:6'h1f]}) |=> pslverr)
        else $error("unmapped access accepted");
    no_memsel_a: assert property (win_s ##0 (ms_reg == 2'h0) |=> pslverr)
        else $error("window access without memory accepted");
    data_ro_a: assert property (win_s ##0 (pwrite && ms_reg == 2'h1 && !sm_reg) |=> pslverr)
        else $error("data memory write accepted");
    upper_zero_a: assert property (pready |-> prdata[31:8] == 24'h0)
        else $error("read data upper bits set");
    ode_float_a: assert property (!global_output_drive_enable [*3] |-> serial_output_streams_oe_n == 8'hff)
        else $error("output driven while drive enable low");
endmodule

bind tsi_top tsi_top_asserts u_chk (.clk_sys, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .global_output_drive_enable, .serial_output_streams_oe_n);

// file: sim/tsi_backplane.sv
`timescale 1ns/1ps
// ========================================
// Backplane partner: serial clock, frame pulse, input streams, capture.
module tsi_backplane (
    input wire logic clk_sys,
    input wire logic rst,
    output logic serial_clock_input,
    output logic frame_sync_input,
    output logic [7:0] serial_input_streams,
    input wire logic [7:0] serial_output_streams,
    input wire logic [7:0] serial_output_streams_oe_n,
    input wire logic control_bit_output
);
    // Halves of 2 and 3 system cycles give about 4 MHz; exact 4.096 cannot be reached.
    logic [2:0] c;
    logic [8:0] k;
    logic [8:0] kn;
    logic [15:0] f;
    logic [7:0] sh [8];
    logic zs [8];
    logic [7:0] rx [8][32];
    logic rxz [8][32];
    logic [15:0] rxf [32];
    logic [7:0] cb [32];

    assign kn = k + 9'h1;

    function automatic logic [7:0] in_byte(input int s, input int ch, input int fr);
        return {fr[2:0], ch[4:0]} ^ {5'h0, s[2:0]};
    endfunction

    always @(posedge clk_sys) begin
        logic [7:0] ib;
        if (rst) begin
            c <= 3'h0;
            k <= 9'h0;
            f <= 16'h0;
            serial_clock_input <= 1'b0;
            frame_sync_input <= 1'b1;
            serial_input_streams <= 8'h00;
        end else begin
            c <= (c == 3'h4) ? 3'h0 : c + 3'h1;
            if (c == 3'h1) begin
                serial_clock_input <= 1'b1;
                frame_sync_input <= (k != 9'h1ff);
                if (k[0]) begin
                    for (int s = 0; s < 8; s++) begin
                        sh[s] <= {sh[s][6:0], serial_output_streams[s]};
                        zs[s] <= (k[3:1] == 3'h0) ? serial_output_streams_oe_n[s]
                            : zs[s] | serial_output_streams_oe_n[s];
                        if (k[3:1] == 3'h7) begin
                            rx[s][k[8:4]] <= {sh[s][6:0], serial_output_streams[s]};
                            rxz[s][k[8:4]] <= zs[s] | serial_output_streams_oe_n[s];
                        end
                    end
                    cb[k[8:4]][k[3:1]] <= control_bit_output;
                    rxf[k[8:4]] <= f;
                end
            end
            if (c == 3'h4) begin
                serial_clock_input <= 1'b0;
                k <= kn;
                if (kn == 9'h0) f <= f + 16'h1;
                if (!kn[0]) begin
                    for (int s = 0; s < 8; s++) begin
                        ib = in_byte(s, kn[8:4], (kn == 9'h0) ? f + 1 : f);
                        serial_input_streams[s] <= ib[3'h7 - kn[3:1]];
                    end
                end
            end
        end
    end
endmodule

// file: sim/tb.sv
`timescale 1ns/1ps
// ========================================
// Bench top: register access, routing, delays, drive enable.
module tb;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, serial_clock_input, frame_sync_input, control_bit_output;
    logic global_output_drive_enable = 1'b1;
    logic [7:0] serial_input_streams, serial_output_streams, serial_output_streams_oe_n;
    int miscompares = 0;
    int n_tests = 0;
    int rm [7] = '{3, 2, 1, 20, 25, 31, 0};
    int rn [7] = '{0, 0, 5, 10, 0, 0, 31};
    bit rc [7] = '{0, 0, 0, 0, 0, 1, 1};

    always #25 clk_sys = ~clk_sys;

    tsi_top DUT (.clk_sys, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .serial_clock_input, .frame_sync_input, .serial_input_streams,
        .global_output_drive_enable, .serial_output_streams, .serial_output_streams_oe_n,
        .control_bit_output);
    tsi_backplane P (.clk_sys, .rst, .serial_clock_input, .frame_sync_input,
        .serial_input_streams, .serial_output_streams, .serial_output_streams_oe_n,
        .control_bit_output);

    task automatic test_done();
        if (miscompares == 0 && n_tests > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
        input logic err, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 20);
        q = prdata;
        check("pready", 32'h1, {31'h0, pready});
        check("pslverr", {31'h0, err}, {31'h0, pslverr});
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic err);
        logic [31:0] q;
        apb(1'b1, a, d, err, q);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic err);
        logic [31:0] q;
        apb(1'b0, a, 32'h0, err, q);
        check("prdata", exp, q);
    endtask

    task automatic wait_frames(input int n);
        int t;
        t = int'(P.f) + n;
        while (int'(P.f) != t) @(posedge clk_sys);
    endtask

    task automatic t_regs();
        logic [31:0] q;
        rd(8'h00, 32'h0, 1'b0);
        wr(8'h00, 32'h93, 1'b0);
        rd(8'h00, 32'h93, 1'b0);
        wr(8'h04, 32'h1, 1'b1);
        rd(8'h08, 32'h0, 1'b1);
        wr(8'h00, 32'h0, 1'b0);
        rd(8'h80, 32'h0, 1'b1);
        wr(8'h00, 32'h08, 1'b0);
        wr(8'h80, 32'h55, 1'b1);
        apb(1'b0, 8'hfc, 32'h0, 1'b0, q);
    endtask

    task automatic t_route();
        int d;
        wr(8'h00, 32'h10, 1'b0);
        for (int i = 0; i < 7; i++) wr(8'(8'h80 + 4 * rm[i]), {27'h0, 3'h1, 5'(rn[i])}, 1'b0);
        wr(8'ha8, 32'ha5, 1'b0);
        wr(8'h00, 32'h18, 1'b0);
        for (int i = 0; i < 7; i++) wr(8'(8'h80 + 4 * rm[i]), rc[i] ? 32'h9 : 32'h1, 1'b0);
        wr(8'ha8, 32'h7, 1'b0);
        wait_frames(4);
        rd(8'h04, 32'h1, 1'b0);
        for (int i = 0; i < 7; i++) begin
            d = rc[i] ? 2 : ((rm[i] > rn[i] + 2) ? 0 : 1);
            check("route", {24'h0, P.in_byte(1, rn[i], P.rxf[rm[i]] - d)}, {24'h0, P.rx[0][rm[i]]});
            check("route_oe", 32'h0, {31'h0, P.rxz[0][rm[i]]});
        end
        check("message", 32'ha5, {24'h0, P.rx[0][10]});
        check("ctl_bits", 32'h01, {24'h0, P.cb[10]});
        check("ctl_zero", 32'h00, {24'h0, P.cb[3]});
        check("slot_z", 32'h1, {31'h0, P.rxz[0][11]});
        check("stream_z", 32'h1, {31'h0, P.rxz[1][5]});
        wait_frames(1);
        check("repeat", 32'ha5, {24'h0, P.rx[0][10]});
        wr(8'h00, 32'h10, 1'b0);
        wr(8'ha8, 32'h3c, 1'b0);
        wait_frames(2);
        check("rewrite", 32'h3c, {24'h0, P.rx[0][10]});
    endtask

    task automatic t_ode();
        global_output_drive_enable <= 1'b0;
        wait_frames(2);
        check("ode_msg", 32'h1, {31'h0, P.rxz[0][10]});
        check("ode_route", 32'h1, {31'h0, P.rxz[0][3]});
        global_output_drive_enable <= 1'b1;
        wait_frames(2);
        check("ode_back", 32'h0, {31'h0, P.rxz[0][10]});
    endtask

    initial begin
        repeat (3) @(posedge clk_sys);
        rst <= 1'b0;
        t_regs();
        t_route();
        t_ode();
        test_done();
    end

    // About eleven frames are needed; the limit leaves ample margin.
    initial begin
        repeat (60000) @(posedge clk_sys);
        miscompares++;
        test_done();
    end
endmodule
